// ===== shared/dup_pkg.sv
// Function
// - Only the selected channel reaches the shared pins; select 1 picks channel 1.
// - Loopback and select bits choose normal channel 0/1 or cross-channel loopback.
// - Every asynchronous byte travels least significant bit first.
// - Parity enable, parity polarity and one or two stop bits; 300 to 115200 baud.
// - Channel 0 sync mode: receive pin carries data, transmit pin shift clock, clock/12.
// - Sync reception starts once receive-complete is 0 and receive enable is 1.
// - Asynchronous reception starts on a start bit while receive enable is 1.
// - Channel 0 mode 1 frame: start 0, eight data bits, stop 1.
// - Mode 1 reception stores data in the buffer, stop bit in ninth-bit flag.
// - Mode 1 bit rate comes from reload generator or timer 1 as configured.
// - Mode 2 frame: start, eight data, ninth bit, stop; rate clock/32 or clock/64.
// - 11-bit modes send the transmit ninth bit, or parity when parity is enabled, and store received ninth bit.
// - Mode 3 uses the mode 2 frame with generator or timer 1 rate.
// - Timer 1 rate: 2^doubler times clock over 384 times (256 minus high byte).
// - Generator rate: 2^doubler times clock over 64 times (1024 minus reload).
// - Channel 1 rate: clock over 32 times (1024 minus reload); no timer option.
// - Reload value is high register bits 1:0 above low register bits 7:0.
// - Channel 1 mode 0 adds a ninth bit; mode 1 is plain eight bits.
// - Writing channel 0 buffer sends a byte; reading returns last received byte.
package dup_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int NUM_CH = 2;
   // Register indexes; byte address is four times the index
   localparam logic [15:0] IDX_SERIAL0_CONTROL = 16'h009b;
   localparam logic [15:0] IDX_CH0_DATA = 16'h009c;
   localparam logic [15:0] IDX_CH0_REL_LO = 16'h009d;
   localparam logic [15:0] IDX_CH0_REL_HI = 16'h009e;
   localparam logic [15:0] IDX_SERIAL1_CONTROL = 16'h009f;
   localparam logic [15:0] IDX_CH1_DATA = 16'h00a0;
   localparam logic [15:0] IDX_CH1_REL_LO = 16'h00a1;
   localparam logic [15:0] IDX_CH1_REL_HI = 16'h00a2;
   localparam logic [15:0] IDX_SERIAL_CONFIG = 16'h00a3;
   localparam logic [15:0] IDX_PIN_POWER = 16'hfff1;
   // Serial control fields (both channels)
   localparam int SC_MODE_HI = 7;
   localparam int SC_MODE_LO = 6;
   localparam int SC_REN = 4;
   localparam int SC_TB9 = 3;
   localparam int SC_RB9 = 2;
   localparam int SC_TI = 1;
   localparam int SC_RI = 0;
   // Serial config fields
   localparam int CFG_DOUBLER = 0;
   localparam int CFG_INTGEN = 1;
   localparam int CFG_PAR_EN = 2;
   localparam int CFG_PAR_ODD = 3;
   localparam int CFG_TWO_STOP = 4;
   // Pin and power control fields
   localparam int PP_POWER_DOWN = 7;
   localparam int PP_LOOPBACK = 1;
   localparam int PP_PORT_SEL = 0;
   localparam logic [7:0] PP_MASK = 8'h83;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] REL_RESET = 10'h000;
   // Timing
   localparam logic [3:0] OS_LAST = 4'hf;
   localparam logic [3:0] HALF_BIT = 4'h7;
   localparam logic [3:0] FRAME_BASE = 4'ha;
   localparam logic [3:0] DATA_BITS = 4'h8;
   localparam logic [3:0] MC_LAST = 4'hb;
   localparam logic [3:0] MC_HALF = 4'h6;
   localparam logic [4:0] PRE_INT_FAST = 5'h02;
   localparam logic [4:0] PRE_INT_SLOW = 5'h04;
   localparam logic [4:0] PRE_T1_FAST = 5'h0c;
   localparam logic [4:0] PRE_T1_SLOW = 5'h18;
   localparam logic [4:0] PRE_CH1 = 5'h02;
   localparam logic [10:0] RELOAD_SPAN = 11'h400;
   localparam logic [10:0] T1_SPAN = 11'h100;
   typedef enum logic [1:0] {DUP_MODE_SYNC, DUP_MODE_8BIT, DUP_MODE_9BIT_FIXED, DUP_MODE_9BIT_VAR} dup_mode_t;
   typedef enum logic [1:0] {DUP_IDLE, DUP_START, DUP_SHIFT} dup_state_t;
endpackage

// ===== design/dup_uart.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dup_uart (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [dup_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [dup_pkg::DATA_W-1:0] dat_i,
   output logic [dup_pkg::DATA_W-1:0] dat_o,
   output logic ack_o,
   // Shared serial pins
   input wire logic rx_i,
   output logic rx_o,
   output logic rx_oe_n_o,
   output logic tx_o,
   // Timer and power
   input wire logic [7:0] timer1_high_byte_i,
   output logic power_down_o
);
   import dup_pkg::*;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
      hit = (a == idx);
   endfunction

   // Bus
   logic ack;
   logic next_ack;
   logic [DATA_W-1:0] rdat;
   logic [DATA_W-1:0] next_rdat;
   logic [15:0] adr_idx;
   logic wr_en;
   logic [7:0] wdat;

   // Registers
   logic [7:0] ctl [NUM_CH];
   logic [7:0] next_ctl [NUM_CH];
   logic [7:0] rbuf [NUM_CH];
   logic [7:0] next_rbuf [NUM_CH];
   logic [9:0] rel [NUM_CH];
   logic [9:0] next_rel [NUM_CH];
   logic [7:0] cfg;
   logic [7:0] next_cfg;
   logic [7:0] ppc;
   logic [7:0] next_ppc;

   // Engines
   dup_state_t tx_st [NUM_CH];
   dup_state_t next_tx_st [NUM_CH];
   dup_state_t rx_st [NUM_CH];
   dup_state_t next_rx_st [NUM_CH];
   logic [11:0] tx_sh [NUM_CH];
   logic [11:0] next_tx_sh [NUM_CH];
   logic [9:0] rx_sh [NUM_CH];
   logic [9:0] next_rx_sh [NUM_CH];
   logic [3:0] tx_cnt [NUM_CH];
   logic [3:0] next_tx_cnt [NUM_CH];
   logic [3:0] tx_tk [NUM_CH];
   logic [3:0] next_tx_tk [NUM_CH];
   logic [3:0] rx_cnt [NUM_CH];
   logic [3:0] next_rx_cnt [NUM_CH];
   logic [3:0] rx_tk [NUM_CH];
   logic [3:0] next_rx_tk [NUM_CH];

   // Rate generation
   logic [4:0] pre [NUM_CH];
   logic [4:0] next_pre [NUM_CH];
   logic [10:0] div [NUM_CH];
   logic [10:0] next_div [NUM_CH];
   logic [4:0] pre_lim [NUM_CH];
   logic [10:0] div_lim [NUM_CH];
   logic tick [NUM_CH];
   logic [3:0] mc;
   logic [3:0] next_mc;
   logic mc_end;
   logic mc_sample;

   // Line routing
   logic rx_in [NUM_CH];
   logic tx_line [NUM_CH];
   logic pd;
   logic sync0;
   logic sclk;
   dup_mode_t mode0;

   assign pd = ppc[PP_POWER_DOWN];
   assign mode0 = dup_mode_t'(ctl[0][SC_MODE_HI:SC_MODE_LO]);
   assign sync0 = (mode0 == DUP_MODE_SYNC);
   assign adr_idx = adr_i[ADDR_W-1:2];
   assign wdat = dat_i[7:0];
   // Writes land on the edge where the master sees ack
   assign wr_en = cyc_i && stb_i && we_i && ack && sel_i[0];

   // ---------------- Bus slave ----------------
   always_comb begin
      next_ack = cyc_i && stb_i && !ack;
      next_rdat = rdat;
      if (cyc_i && stb_i && !ack) begin
         next_rdat = '0;
         if (hit(adr_idx, IDX_SERIAL0_CONTROL)) begin
            next_rdat[7:0] = ctl[0];
         end else if (hit(adr_idx, IDX_CH0_DATA)) begin
            next_rdat[7:0] = rbuf[0];
         end else if (hit(adr_idx, IDX_CH0_REL_LO)) begin
            next_rdat[7:0] = rel[0][7:0];
         end else if (hit(adr_idx, IDX_CH0_REL_HI)) begin
            next_rdat[1:0] = rel[0][9:8];
         end else if (hit(adr_idx, IDX_SERIAL1_CONTROL)) begin
            next_rdat[7:0] = ctl[1];
         end else if (hit(adr_idx, IDX_CH1_DATA)) begin
            next_rdat[7:0] = rbuf[1];
         end else if (hit(adr_idx, IDX_CH1_REL_LO)) begin
            next_rdat[7:0] = rel[1][7:0];
         end else if (hit(adr_idx, IDX_CH1_REL_HI)) begin
            next_rdat[1:0] = rel[1][9:8];
         end else if (hit(adr_idx, IDX_SERIAL_CONFIG)) begin
            next_rdat[7:0] = cfg;
         end else if (hit(adr_idx, IDX_PIN_POWER)) begin
            next_rdat[7:0] = ppc;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         rdat <= '0;
      end else begin
         ack <= next_ack;
         rdat <= next_rdat;
      end
   end

   assign ack_o = ack;
   assign dat_o = rdat;

   // ---------------- Rate generators ----------------
   always_comb begin
      // Channel 0: fixed, internal reload or timer 1 source
      if (mode0 == DUP_MODE_9BIT_FIXED) begin
         pre_lim[0] = cfg[CFG_DOUBLER] ? PRE_INT_FAST : PRE_INT_SLOW;
         div_lim[0] = 11'h001;
      end else if (cfg[CFG_INTGEN]) begin
         pre_lim[0] = cfg[CFG_DOUBLER] ? PRE_INT_FAST : PRE_INT_SLOW;
         div_lim[0] = RELOAD_SPAN - {1'b0, rel[0]};
      end else begin
         pre_lim[0] = cfg[CFG_DOUBLER] ? PRE_T1_FAST : PRE_T1_SLOW;
         div_lim[0] = T1_SPAN - {3'b000, timer1_high_byte_i};
      end
      pre_lim[1] = PRE_CH1;
      div_lim[1] = RELOAD_SPAN - {1'b0, rel[1]};
      next_mc = mc;
      mc_end = 1'b0;
      mc_sample = 1'b0;
      if (!pd) begin
         next_mc = (mc >= MC_LAST) ? 4'h0 : mc + 4'h1;
         mc_end = (mc == MC_LAST);
         mc_sample = (mc == MC_HALF);
      end
      for (int c = 0; c < NUM_CH; c++) begin
         next_pre[c] = pre[c];
         next_div[c] = div[c];
         tick[c] = 1'b0;
         // Oversampling tick runs at sixteen times the bit rate
         if (!pd) begin
            if (pre[c] >= pre_lim[c] - 5'h01) begin
               next_pre[c] = 5'h00;
               if (div[c] >= div_lim[c] - 11'h001) begin
                  next_div[c] = 11'h000;
                  tick[c] = 1'b1;
               end else begin
                  next_div[c] = div[c] + 11'h001;
               end
            end else begin
               next_pre[c] = pre[c] + 5'h01;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mc <= 4'h0;
         for (int c = 0; c < NUM_CH; c++) begin
            pre[c] <= 5'h00;
            div[c] <= 11'h000;
         end
      end else begin
         mc <= next_mc;
         for (int c = 0; c < NUM_CH; c++) begin
            pre[c] <= next_pre[c];
            div[c] <= next_div[c];
         end
      end
   end

   // ---------------- Registers and serial engines ----------------
   always_comb begin
      logic nine;
      logic sync;
      logic ninth;
      logic bit_end;
      logic [9:0] sh;
      nine = 1'b0;
      sync = 1'b0;
      ninth = 1'b0;
      bit_end = 1'b0;
      sh = '0;
      next_ctl = ctl;
      next_rbuf = rbuf;
      next_rel = rel;
      next_cfg = cfg;
      next_ppc = ppc;
      next_tx_st = tx_st;
      next_rx_st = rx_st;
      next_tx_sh = tx_sh;
      next_rx_sh = rx_sh;
      next_tx_cnt = tx_cnt;
      next_tx_tk = tx_tk;
      next_rx_cnt = rx_cnt;
      next_rx_tk = rx_tk;
      if (wr_en && hit(adr_idx, IDX_SERIAL_CONFIG)) begin
         next_cfg = wdat;
      end
      if (wr_en && hit(adr_idx, IDX_PIN_POWER)) begin
         next_ppc = wdat & PP_MASK;
      end
      for (int c = 0; c < NUM_CH; c++) begin
         nine = (c == 0) ? (mode0 == DUP_MODE_9BIT_FIXED || mode0 == DUP_MODE_9BIT_VAR)
                         : !ctl[1][SC_MODE_HI];
         sync = (c == 0) && sync0;
         // Software writes first so a same-cycle hardware set wins
         if (wr_en && hit(adr_idx, c == 0 ? IDX_SERIAL0_CONTROL : IDX_SERIAL1_CONTROL)) begin
            next_ctl[c] = wdat;
         end
         if (wr_en && hit(adr_idx, c == 0 ? IDX_CH0_REL_LO : IDX_CH1_REL_LO)) begin
            next_rel[c][7:0] = wdat;
         end
         if (wr_en && hit(adr_idx, c == 0 ? IDX_CH0_REL_HI : IDX_CH1_REL_HI)) begin
            next_rel[c][9:8] = wdat[1:0];
         end
         // Transmitter; a buffer write while busy is dropped
         ninth = cfg[CFG_PAR_EN] ? (^wdat ^ cfg[CFG_PAR_ODD]) : ctl[c][SC_TB9];
         case (tx_st[c])
            DUP_IDLE: begin
               if (wr_en && hit(adr_idx, c == 0 ? IDX_CH0_DATA : IDX_CH1_DATA)) begin
                  next_tx_st[c] = sync ? DUP_START : DUP_SHIFT;
                  next_tx_tk[c] = 4'h0;
                  if (sync) begin
                     next_tx_sh[c] = {4'hf, wdat};
                     next_tx_cnt[c] = DATA_BITS;
                  end else begin
                     next_tx_sh[c] = {2'b11, nine ? ninth : 1'b1, wdat, 1'b0};
                     next_tx_cnt[c] = FRAME_BASE + {3'b000, nine} + {3'b000, cfg[CFG_TWO_STOP]};
                  end
               end
            end
            DUP_SHIFT: begin
               bit_end = sync ? mc_end : (tick[c] && tx_tk[c] == OS_LAST);
               if (!sync && tick[c]) begin
                  next_tx_tk[c] = tx_tk[c] + 4'h1;
               end
               if (bit_end) begin
                  next_tx_sh[c] = {1'b1, tx_sh[c][11:1]};
                  next_tx_cnt[c] = tx_cnt[c] - 4'h1;
                  if (tx_cnt[c] == 4'h1) begin
                     next_tx_st[c] = DUP_IDLE;
                     next_ctl[c][SC_TI] = 1'b1;
                  end
               end
            end
            // Sync transfers wait for a machine-cycle boundary so no shift clock is cut short
            DUP_START: next_tx_st[c] = mc_end ? DUP_SHIFT : DUP_START;
            default: next_tx_st[c] = DUP_IDLE;
         endcase
         // Receiver
         case (rx_st[c])
            DUP_IDLE: begin
               next_rx_tk[c] = 4'h0;
               if (sync && !ctl[c][SC_RI] && ctl[c][SC_REN] && mc_end) begin
                  next_rx_st[c] = DUP_SHIFT;
                  next_rx_cnt[c] = DATA_BITS;
               end else if (!sync && tick[c] && ctl[c][SC_REN] && !rx_in[c]) begin
                  next_rx_st[c] = DUP_START;
               end
            end
            DUP_START: begin
               if (tick[c]) begin
                  next_rx_tk[c] = rx_tk[c] + 4'h1;
                  if (rx_tk[c] == HALF_BIT) begin
                     // A glitch shorter than half a bit is not a start bit
                     next_rx_st[c] = rx_in[c] ? DUP_IDLE : DUP_SHIFT;
                     next_rx_tk[c] = 4'h0;
                     next_rx_cnt[c] = FRAME_BASE - 4'h1 + {3'b000, nine};
                  end
               end
            end
            DUP_SHIFT: begin
               bit_end = sync ? mc_sample : (tick[c] && rx_tk[c] == OS_LAST);
               if (!sync && tick[c]) begin
                  next_rx_tk[c] = rx_tk[c] + 4'h1;
               end
               if (bit_end) begin
                  sh = {rx_in[c], rx_sh[c][9:1]};
                  next_rx_sh[c] = sh;
                  next_rx_cnt[c] = rx_cnt[c] - 4'h1;
                  if (rx_cnt[c] == 4'h1) begin
                     next_rx_st[c] = DUP_IDLE;
                     next_ctl[c][SC_RI] = 1'b1;
                     if (sync) begin
                        next_rbuf[c] = sh[9:2];
                     end else if (nine) begin
                        next_rbuf[c] = sh[7:0];
                        next_ctl[c][SC_RB9] = sh[8];
                     end else begin
                        next_rbuf[c] = sh[8:1];
                        next_ctl[c][SC_RB9] = sh[9];
                     end
                  end
               end
            end
            default: next_rx_st[c] = DUP_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg <= REG_RESET;
         ppc <= REG_RESET;
         for (int c = 0; c < NUM_CH; c++) begin
            ctl[c] <= REG_RESET;
            rbuf[c] <= REG_RESET;
            rel[c] <= REL_RESET;
            tx_st[c] <= DUP_IDLE;
            rx_st[c] <= DUP_IDLE;
            tx_sh[c] <= 12'hfff;
            rx_sh[c] <= 10'h000;
            tx_cnt[c] <= 4'h0;
            tx_tk[c] <= 4'h0;
            rx_cnt[c] <= 4'h0;
            rx_tk[c] <= 4'h0;
         end
      end else begin
         cfg <= next_cfg;
         ppc <= next_ppc;
         for (int c = 0; c < NUM_CH; c++) begin
            ctl[c] <= next_ctl[c];
            rbuf[c] <= next_rbuf[c];
            rel[c] <= next_rel[c];
            tx_st[c] <= next_tx_st[c];
            rx_st[c] <= next_rx_st[c];
            tx_sh[c] <= next_tx_sh[c];
            rx_sh[c] <= next_rx_sh[c];
            tx_cnt[c] <= next_tx_cnt[c];
            tx_tk[c] <= next_tx_tk[c];
            rx_cnt[c] <= next_rx_cnt[c];
            rx_tk[c] <= next_rx_tk[c];
         end
      end
   end

   // ---------------- Pin routing ----------------
   // Shift clock is low for the first half of each machine cycle while busy
   assign sclk = !(sync0 && (tx_st[0] == DUP_SHIFT || rx_st[0] == DUP_SHIFT) && mc < MC_HALF);
   assign tx_line[0] = sync0 ? sclk : ((tx_st[0] == DUP_SHIFT) ? tx_sh[0][0] : 1'b1);
   assign tx_line[1] = (tx_st[1] == DUP_SHIFT) ? tx_sh[1][0] : 1'b1;

   always_comb begin
      // Unselected receivers see an idle line
      rx_in[0] = 1'b1;
      rx_in[1] = 1'b1;
      case ({ppc[PP_LOOPBACK], ppc[PP_PORT_SEL]})
         2'b00: rx_in[0] = rx_i;
         2'b01: rx_in[1] = rx_i;
         2'b10: rx_in[1] = tx_line[0];
         2'b11: rx_in[0] = tx_line[1];
         default: rx_in[0] = 1'b1;
      endcase
   end

   assign tx_o = ppc[PP_PORT_SEL] ? tx_line[1] : tx_line[0];
   // Receive pin is driven only for a sync transmit on the selected channel 0
   assign rx_oe_n_o = !(!ppc[PP_PORT_SEL] && sync0 && tx_st[0] == DUP_SHIFT);
   assign rx_o = tx_sh[0][0];
   assign power_down_o = pd;
endmodule // dup_uart

// ===== tb/dup_uart_properties.sv
`timescale 1ns/1ps
module dup_uart_properties (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [dup_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [dup_pkg::DATA_W-1:0] dat_i,
   input wire logic [dup_pkg::DATA_W-1:0] dat_o,
   input wire logic ack_o,
   // Pins
   input wire logic rx_oe_n_o,
   input wire logic tx_o,
   input wire logic power_down_o
);
   import dup_pkg::*;
   logic rd_ack;
   logic pp_wr;
   assign rd_ack = ack_o && cyc_i && !we_i;
   assign pp_wr = ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i[17:2] == IDX_PIN_POWER;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_taken;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_pp_write;
      pp_wr;
   endsequence
   a_ack_follows: assert property (s_taken |=> ack_o)
      else $error("ack missing after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_needs_req: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   a_power_follows: assert property (s_pp_write |=> power_down_o == $past(dat_i[PP_POWER_DOWN]))
      else $error("power down not taken from write");
   a_power_holds: assert property (!pp_wr |=> $stable(power_down_o))
      else $error("power down changed without write");
   a_pp_readback: assert property (rd_ack && adr_i[17:2] == IDX_PIN_POWER
      |-> (dat_o[7:0] & ~PP_MASK) == 8'h00 && dat_o[7] == power_down_o)
      else $error("pin control read wrong");
   a_upper_zero: assert property (rd_ack |-> dat_o[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_unmapped_zero: assert property (rd_ack && adr_i[17:2] == 16'h0001 |-> dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_low_min_six: assert property ($fell(tx_o) |-> !tx_o [*6])
      else $error("transmit low pulse too short");
   a_reset_idle: assert property (disable iff (1'b0) rst_i |=> tx_o && rx_oe_n_o && !ack_o && !power_down_o)
      else $error("outputs not idle in reset");
endmodule // dup_uart_properties

bind dup_uart dup_uart_properties dup_uart_properties_i (
   .clk_i(clk_i),
   .rst_i(rst_i),
   .cyc_i(cyc_i),
   .stb_i(stb_i),
   .we_i(we_i),
   .adr_i(adr_i),
   .sel_i(sel_i),
   .dat_i(dat_i),
   .dat_o(dat_o),
   .ack_o(ack_o),
   .rx_oe_n_o(rx_oe_n_o),
   .tx_o(tx_o),
   .power_down_o(power_down_o)
);

// ===== tb/dup_host.sv
`timescale 1ns/1ps
module dup_host (
   // Clock
   input wire logic clk_i,
   // Serial line
   input wire logic line_i,
   output logic line_o,
   // Frame setup
   input wire logic [15:0] bit_clks_i,
   input wire logic nine_i,
   // Captured frame
   output logic [8:0] got_o,
   output logic [7:0] got_cnt_o
);
   logic [8:0] shift;
   initial begin
      line_o = 1'b1;
      got_o = 9'h000;
      got_cnt_o = 8'h00;
   end
   // Mid-bit sampling: a wrong device rate shows up as corrupted data
   always begin
      @(negedge line_i);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      if (line_i === 1'b0) begin
         shift = 9'h000;
         for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
            repeat (bit_clks_i) @(posedge clk_i);
            shift[i] = line_i;
         end
         repeat (bit_clks_i) @(posedge clk_i);
         if (line_i === 1'b1) begin
            got_o <= shift;
            got_cnt_o <= got_cnt_o + 8'h01;
         end
      end
   end
   task send(input logic [8:0] d);
      @(posedge clk_i);
      line_o <= 1'b0;
      repeat (bit_clks_i) @(posedge clk_i);
      for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
         line_o <= d[i];
         repeat (bit_clks_i) @(posedge clk_i);
      end
      line_o <= 1'b1;
      repeat (bit_clks_i) @(posedge clk_i);
   endtask
endmodule // dup_host

// ===== tb/test_dup_uart.sv
`timescale 1ns/1ps
module test_dup_uart;
   import dup_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [ADDR_W-1:0] adr_i = 18'h00000;
   logic [3:0] sel_i = 4'h0;
   logic [DATA_W-1:0] dat_i = 32'h00000000;
   logic [DATA_W-1:0] dat_o;
   logic ack_o;
   logic rx_i;
   logic tx_o;
   logic power_down_o;
   logic [7:0] th1 = 8'h00;
   logic [15:0] bit_clks = 16'h00e0;
   logic nine = 1'b0;
   logic [8:0] got;
   logic [7:0] got_cnt;
   logic [7:0] rd;
   logic quiet;
   logic rx_drive;
   logic rx_oe_n;
   logic last_sck;
   logic [7:0] sy;
   int nclk;
   int errors = 0;
   int checks = 0;
   always #20 clk_i = ~clk_i;
   dup_uart dup_uart_i (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(cyc_i),
      .stb_i(stb_i),
      .we_i(we_i),
      .adr_i(adr_i),
      .sel_i(sel_i),
      .dat_i(dat_i),
      .dat_o(dat_o),
      .ack_o(ack_o),
      .rx_i(rx_i),
      .rx_o(rx_drive),
      .rx_oe_n_o(rx_oe_n),
      .tx_o(tx_o),
      .timer1_high_byte_i(th1),
      .power_down_o(power_down_o)
   );
   dup_host dup_host_i (
      .clk_i(clk_i),
      .line_i(tx_o),
      .line_o(rx_i),
      .bit_clks_i(bit_clks),
      .nine_i(nine),
      .got_o(got),
      .got_cnt_o(got_cnt)
   );
   task test_done;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [8:0] g, input logic [8:0] e);
      checks++;
      if (g !== e) begin
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
         errors++;
      end
   endtask
   // Holds the request until ack, then leaves one idle cycle
   task bus(input logic w, input logic [15:0] idx, input logic [7:0] d);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      sel_i <= 4'h1;
      dat_i <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      rd = dat_o[7:0];
      if (ack_o !== 1'b1) begin
         errors++;
         test_done();
      end
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task wr(input logic [15:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task rd_chk(input logic [15:0] idx, input logic [7:0] e);
      bus(1'b0, idx, 8'h00);
      chk({1'b0, rd}, {1'b0, e});
   endtask
   task wait_bit(input logic [15:0] idx, input int b);
      int n;
      n = 0;
      do begin
         bus(1'b0, idx, 8'h00);
         n++;
      end while (rd[b] !== 1'b1 && n < 2000);
      if (rd[b] !== 1'b1) begin
         errors++;
         test_done();
      end
   endtask
   task wait_host(input logic [7:0] c);
      int n;
      n = 0;
      while (got_cnt !== c && n < 4000) begin
         @(posedge clk_i);
         n++;
      end
      if (got_cnt !== c) begin
         errors++;
         test_done();
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(IDX_SERIAL0_CONTROL, 8'h00);
      rd_chk(IDX_PIN_POWER, 8'h00);
      rd_chk(16'h0001, 8'h00);
      // Reload 0x3f9 with doubler: 32*7 clocks a bit
      wr(IDX_CH0_REL_LO, 8'hf9);
      wr(IDX_CH0_REL_HI, 8'h03);
      wr(IDX_SERIAL_CONFIG, 8'h03);
      wr(IDX_SERIAL0_CONTROL, 8'h50);
      wr(IDX_CH0_DATA, 8'ha5);
      wait_host(8'h01);
      chk(got, 9'h0a5);
      wait_bit(IDX_SERIAL0_CONTROL, 1);
      dup_host_i.send(9'h03c);
      wait_bit(IDX_SERIAL0_CONTROL, 0);
      rd_chk(IDX_SERIAL0_CONTROL, 8'h57);
      rd_chk(IDX_CH0_DATA, 8'h3c);
      // Fixed rate with doubler: 32 clocks a bit
      bit_clks <= 16'h0020;
      nine <= 1'b1;
      wr(IDX_SERIAL0_CONTROL, 8'h98);
      wr(IDX_CH0_DATA, 8'h5a);
      wait_host(8'h02);
      chk(got, 9'h15a);
      dup_host_i.send(9'h0c3);
      wait_bit(IDX_SERIAL0_CONTROL, 0);
      rd_chk(IDX_SERIAL0_CONTROL, 8'h9b);
      rd_chk(IDX_CH0_DATA, 8'hc3);
      // Timer 1 byte 0xff with doubler: 192 clocks a bit, odd parity
      th1 <= 8'hff;
      bit_clks <= 16'h00c0;
      wr(IDX_SERIAL_CONFIG, 8'h0d);
      wr(IDX_SERIAL0_CONTROL, 8'hd0);
      wr(IDX_CH0_DATA, 8'h81);
      wait_host(8'h03);
      chk(got, 9'h181);
      // Channel 1 on the pins
      bit_clks <= 16'h00e0;
      nine <= 1'b0;
      wr(IDX_SERIAL_CONFIG, 8'h03);
      wr(IDX_PIN_POWER, 8'h01);
      wr(IDX_CH1_REL_LO, 8'hf9);
      wr(IDX_CH1_REL_HI, 8'h03);
      wr(IDX_SERIAL1_CONTROL, 8'h90);
      wr(IDX_CH1_DATA, 8'h96);
      wait_host(8'h04);
      chk(got, 9'h096);
      dup_host_i.send(9'h069);
      wait_bit(IDX_SERIAL1_CONTROL, 0);
      rd_chk(IDX_CH1_DATA, 8'h69);
      // Channel 0 sends a whole frame but must stay off the pins
      wr(IDX_SERIAL0_CONTROL, 8'h50);
      wr(IDX_CH0_DATA, 8'h11);
      quiet = 1'b1;
      repeat (2600) begin
         @(posedge clk_i);
         quiet = quiet & (tx_o === 1'b1);
      end
      chk({8'h00, quiet}, 9'h001);
      wr(IDX_SERIAL1_CONTROL, 8'h90);
      wr(IDX_PIN_POWER, 8'h02);
      wr(IDX_CH0_DATA, 8'h77);
      wait_bit(IDX_SERIAL1_CONTROL, 0);
      rd_chk(IDX_CH1_DATA, 8'h77);
      wr(IDX_SERIAL0_CONTROL, 8'h50);
      wr(IDX_PIN_POWER, 8'h03);
      wr(IDX_CH1_DATA, 8'h3a);
      wait_bit(IDX_SERIAL0_CONTROL, 0);
      rd_chk(IDX_CH0_DATA, 8'h3a);
      wr(IDX_PIN_POWER, 8'hff);
      rd_chk(IDX_PIN_POWER, 8'h83);
      chk({8'h00, power_down_o}, 9'h001);
      wr(IDX_PIN_POWER, 8'h00);
      // Sync mode: data bits on the driven receive pin, taken at each shift clock rise
      wr(IDX_SERIAL0_CONTROL, 8'h00);
      wr(IDX_CH0_DATA, 8'h6b);
      sy = 8'h00;
      nclk = 0;
      last_sck = 1'b1;
      repeat (400) begin
         @(posedge clk_i);
         if (tx_o === 1'b1 && last_sck === 1'b0 && rx_oe_n === 1'b0) begin
            sy = {rx_drive, sy[7:1]};
            nclk++;
         end
         last_sck = tx_o;
      end
      chk({1'b0, sy}, 9'h06b);
      chk(nclk[8:0], 9'h008);
      wr(IDX_SERIAL0_CONTROL, 8'h10);
      wait_bit(IDX_SERIAL0_CONTROL, 0);
      rd_chk(IDX_CH0_DATA, 8'hff);
      test_done();
   end
endmodule // test_dup_uart
